// ### logic/qaw_consts.svh
// Register offsets, field values and reset values of the Q&A watchdog
`ifndef QAW_CONSTS_SVH
`define QAW_CONSTS_SVH

// Register byte offsets
`define QAW_OFS_QUESTION     8'h00
`define QAW_OFS_RESULT       8'h04
`define QAW_OFS_ANSWER       8'h08
`define QAW_OFS_WIN1         8'h0C
`define QAW_OFS_WIN2         8'h10
`define QAW_OFS_FEEDBACK     8'h14

// Field widths
`define QAW_WIN_W            8
`define QAW_FDBK_W           4

// Answer byte index values
`define QAW_IDX_FIRST        2'b11
`define QAW_IDX_LAST         2'b00
`define QAW_IDX_STEP         2'b01

// Reset values, increments and limits
`define QAW_STEP_RST         4'h0
`define QAW_MARKOV_RST       4'h0
`define QAW_STEP_ONE         4'h1
`define QAW_STEP_MAX         4'hF
`define QAW_TALLY_RST        3'h0
`define QAW_TALLY_MAX        3'h7
`define QAW_TALLY_ONE        3'h1
`define QAW_WIN_RST          8'h00
`define QAW_FDBK_DEFAULT     4'h0

`endif

// ### logic/qaw_pkg.sv
// Types shared by the Q&A watchdog design
package qaw_pkg;

  // Watchdog result register layout, bit 9 down to bit 0
  typedef struct packed {
    logic [2:0] fail_tally;
    logic [1:0] answer_byte_index;
    logic       sequence_fault;
    logic       window_setting_changed;
    logic       premature;
    logic       no_response;
    logic       answer_mismatch;
  } qaw_result_s;

  // APB request fields as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } qaw_apb_req_s;

  // Sequence end classification
  typedef enum logic [4:0] {
    QAW_EV_NONE    = 5'b00001,
    QAW_EV_GOOD    = 5'b00010,
    QAW_EV_BAD     = 5'b00100,
    QAW_EV_TIMEOUT = 5'b01000,
    QAW_EV_CFG     = 5'b10000
  } qaw_event_e;

endpackage

// ### logic/qaw_watchdog.sv
// Q&A watchdog question generation, answer check and result tally
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "qaw_consts.svh"

module qaw_watchdog (
  // Clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Window timing and SPI frame status
  input  wire logic                 in_second_window,
  input  wire logic                 timeout_event,
  input  wire logic                 spi_cs_n,
  // Watchdog state
  output logic      [3:0]           question,
  output qaw_pkg::qaw_result_s      result,
  output logic      [7:0]           first_window_length,
  output logic      [7:0]           second_window_length,
  output logic                      sequence_restart
);

  logic [3:0]           question_step_counter;
  logic [3:0]           markov;
  logic [3:0]           question_feedback_setting;
  logic                 cs_meta;
  logic                 cs_sync;
  qaw_pkg::qaw_apb_req_s req;
  qaw_pkg::qaw_event_e  ev;
  logic                 wr_en;
  logic                 ans_wr;
  logic                 win_wr;
  logic                 final_wr;
  logic                 mismatch_now;
  logic                 seq_mismatch;
  logic                 frame_active;
  logic [7:0]           ref_byte;
  logic [3:0]           next_markov;
  logic [2:0]           fail_tally;
  logic [1:0]           answer_byte_index;
  logic                 answer_mismatch;
  logic                 sequence_fault;
  logic                 window_setting_changed;
  logic                 premature;
  logic                 no_response;
  logic                 earlier_mismatch;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Answer table row for a question: answers three down to zero
  function automatic logic [31:0] answer_row(input logic [3:0] q);
    case (q)
      4'h0: answer_row = 32'hFF0FF000;
      4'h1: answer_row = 32'hB040BF4F;
      4'h2: answer_row = 32'hE919E616;
      4'h3: answer_row = 32'hA656A959;
      4'h4: answer_row = 32'h75857A8A;
      4'h5: answer_row = 32'h3ACA35C5;
      4'h6: answer_row = 32'h63936C9C;
      4'h7: answer_row = 32'h2CDC23D3;
      4'h8: answer_row = 32'hD222DD2D;
      4'h9: answer_row = 32'h9D6D9262;
      4'hA: answer_row = 32'hC434CB3B;
      4'hB: answer_row = 32'h8B7B8474;
      4'hC: answer_row = 32'h58A857A7;
      4'hD: answer_row = 32'h17E718E8;
      4'hE: answer_row = 32'h4EBE41B1;
      default: answer_row = 32'h01F10EFE;
    endcase
  endfunction

  // Saturating step of the fail tally
  function automatic logic [2:0] tally_step(input logic [2:0] t,
                                            input logic       up);
    tally_step = up ? ((t == `QAW_TALLY_MAX) ? t : t + `QAW_TALLY_ONE)
                    : ((t == `QAW_TALLY_RST) ? t : t - `QAW_TALLY_ONE);
  endfunction

  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  // APB decode, zero wait states
  assign pready       = 1'b1;
  assign wr_en        = ce & req.sel & req.enable & req.write;
  assign ans_wr       = wr_en & (req.addr == `QAW_OFS_ANSWER);
  assign win_wr       = wr_en & ((req.addr == `QAW_OFS_WIN1) |
                                 (req.addr == `QAW_OFS_WIN2));
  assign final_wr     = ans_wr &
                        (result.answer_byte_index == `QAW_IDX_LAST);
  assign frame_active = ~cs_sync;

  assign question = question_step_counter ^ markov;

  // Default feedback leaves table bytes unchanged
  always_comb begin
    logic [31:0] row;
    row      = answer_row(question);
    ref_byte = row[{result.answer_byte_index, 3'b000} +: 8] ^
               {question_feedback_setting, question_feedback_setting};
  end

  assign mismatch_now     = (req.wdata[7:0] != ref_byte);
  assign earlier_mismatch = answer_mismatch &
                            (answer_byte_index != `QAW_IDX_FIRST);
  assign seq_mismatch     = mismatch_now | earlier_mismatch;

  // Sequence end classification; window write wins over all
  always_comb begin
    if (win_wr) begin
      ev = qaw_pkg::QAW_EV_CFG;
    end else if (final_wr) begin
      // Good only with final byte in second window
      ev = (!seq_mismatch && in_second_window) ? qaw_pkg::QAW_EV_GOOD
                                               : qaw_pkg::QAW_EV_BAD;
    end else if (ce && timeout_event) begin
      ev = qaw_pkg::QAW_EV_TIMEOUT;
    end else begin
      ev = qaw_pkg::QAW_EV_NONE;
    end
  end

  assign sequence_restart = (ev != qaw_pkg::QAW_EV_NONE);

  // XNOR feedback moves the chain off zero
  assign next_markov = {markov[2:0], ~(markov[3] ^ markov[2])};

  // Chip select pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
    end else if (ce) begin
      cs_meta <= spi_cs_n;
      cs_sync <= cs_meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      question_step_counter <= `QAW_STEP_RST;
      markov                <= `QAW_MARKOV_RST;
    end else if (ev == qaw_pkg::QAW_EV_GOOD) begin
      // New question at the next edge
      question_step_counter <= question_step_counter + `QAW_STEP_ONE;
      if (question_step_counter == `QAW_STEP_MAX) begin
        markov <= next_markov;
      end
    end
  end

  // Window lengths and feedback setting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_window_length       <= `QAW_WIN_RST;
      second_window_length      <= `QAW_WIN_RST;
      question_feedback_setting <= `QAW_FDBK_DEFAULT;
    end else if (wr_en) begin
      case (req.addr)
        `QAW_OFS_WIN1: first_window_length <= req.wdata[7:0];
        `QAW_OFS_WIN2: second_window_length <= req.wdata[7:0];
        `QAW_OFS_FEEDBACK: question_feedback_setting <= req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Answer index and mismatch flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      answer_byte_index <= `QAW_IDX_FIRST;
      answer_mismatch   <= 1'b0;
    end else if (sequence_restart) begin
      // Each new sequence expects answer three
      // Final byte reloads index to three
      answer_byte_index <= `QAW_IDX_FIRST;
      if (final_wr && !win_wr) begin
        answer_mismatch <= seq_mismatch;
      end
    end else if (ans_wr) begin
      answer_mismatch   <= seq_mismatch;
      answer_byte_index <= answer_byte_index - `QAW_IDX_STEP;
    end
  end

  // Fail tally saturates at both ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fail_tally <= `QAW_TALLY_RST;
    end else if (sequence_restart) begin
      // Good sequence counts down, all others up
      fail_tally <= tally_step(fail_tally, ev != qaw_pkg::QAW_EV_GOOD);
    end
  end

  // Status flags, rewritten at every sequence end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sequence_fault         <= 1'b0;
      window_setting_changed <= 1'b0;
      premature              <= 1'b0;
      no_response            <= 1'b0;
    end else if (sequence_restart) begin
      // Late wrong bytes leave premature clear
      // Flag held off during an SPI frame
      sequence_fault         <= (ev == qaw_pkg::QAW_EV_BAD) |
                                ((ev == qaw_pkg::QAW_EV_TIMEOUT) &
                                 earlier_mismatch);
      window_setting_changed <= (ev == qaw_pkg::QAW_EV_CFG);
      premature              <= (ev == qaw_pkg::QAW_EV_BAD) &
                                ~in_second_window;
      no_response            <= (ev == qaw_pkg::QAW_EV_TIMEOUT) &
                                ~frame_active;
    end
  end

  assign result = {fail_tally, answer_byte_index, sequence_fault,
                   window_setting_changed, premature, no_response,
                   answer_mismatch};

  // Read mux; unmapped offsets read zero with an error
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    case (req.addr)
      `QAW_OFS_QUESTION: prdata[3:0] = question;
      `QAW_OFS_RESULT:   prdata[9:0] = result;
      `QAW_OFS_ANSWER:   prdata      = 32'h00000000;
      `QAW_OFS_WIN1:     prdata[7:0] = first_window_length;
      `QAW_OFS_WIN2:     prdata[7:0] = second_window_length;
      `QAW_OFS_FEEDBACK: prdata[3:0] = question_feedback_setting;
      default:           pslverr     = req.sel & req.enable;
    endcase
  end

  // Checks
  logic seq_end;
  assign seq_end = final_wr & ~win_wr;

  a_good_advance: assert property (
    ev == qaw_pkg::QAW_EV_GOOD |=>
      question_step_counter == $past(question_step_counter) + 4'h1)
    else $error("question not advanced after good sequence");

  a_bad_hold: assert property (
    ev == qaw_pkg::QAW_EV_BAD || ev == qaw_pkg::QAW_EV_TIMEOUT |=>
      $stable(question) && result.sequence_fault ==
      ($past(ev) == qaw_pkg::QAW_EV_BAD || $past(earlier_mismatch)))
    else $error("question changed or fault wrong after bad sequence");

  a_cfg_hold: assert property (
    win_wr |=> $stable(question) && result.window_setting_changed
      && !result.sequence_fault && !result.premature
      && !result.no_response)
    else $error("window write handled wrongly");

  a_markov_wrap: assert property (
    ev == qaw_pkg::QAW_EV_GOOD && question_step_counter == 4'hF
      |=> markov != $past(markov) && question_step_counter == 4'h0)
    else $error("chain did not step on counter wrap");

  a_index_load: assert property (
    sequence_restart |=> result.answer_byte_index == 2'b11)
    else $error("index not reloaded at sequence start");

  a_index_step: assert property (
    ans_wr && !sequence_restart |=>
      result.answer_byte_index == $past(result.answer_byte_index) - 2'b01)
    else $error("index not decremented on answer write");

  a_tally_sat: assert property (
    result.fail_tally == 3'h7 && ev != qaw_pkg::QAW_EV_NONE
      && ev != qaw_pkg::QAW_EV_GOOD |=> result.fail_tally == 3'h7)
    else $error("fail tally wrapped");

  a_early_final: assert property (
    seq_end && !in_second_window |=>
      result.premature && result.sequence_fault
      && result.fail_tally >= $past(result.fail_tally))
    else $error("early final byte not flagged");

  a_frame_timeout: assert property (
    ev == qaw_pkg::QAW_EV_TIMEOUT && frame_active |=>
      !result.no_response)
    else $error("no-response latched during frame");

  a_table_zero: assert property (
    question == 4'h0 && question_feedback_setting == 4'h0
      && result.answer_byte_index == 2'b11 |-> ref_byte == 8'hFF)
    else $error("reference byte off table");

  c_good_seq: cover property (ev == qaw_pkg::QAW_EV_GOOD);
  c_timeout: cover property (
    ev == qaw_pkg::QAW_EV_TIMEOUT ##1 result.no_response);
  c_cfg_change: cover property (ev == qaw_pkg::QAW_EV_CFG);
  c_wrap: cover property (
    ev == qaw_pkg::QAW_EV_GOOD && question_step_counter == 4'hF);

endmodule

// ### verif/qa_watchdog_answer_check_tb.sv
// Self-checking bench for the question and answer watchdog
`timescale 1ns/1ns
module qa_watchdog_answer_check_tb;
  logic                 clk, rst, ce, psel, penable, pwrite;
  logic                 win2, tmo, frame, spi_cs_n, pready, pslverr;
  logic                 slv, restart, rsr;
  logic [7:0]           paddr, w1len, w2len;
  logic [31:0]          pwdata, prdata, rd;
  logic [3:0]           question, step, mk;
  logic [2:0]           tally;
  qaw_pkg::qaw_result_s res;
  int                   n_fail, checks;
  // Answer bytes three down to zero for each question
  logic [31:0] ans [16] = '{
    32'hFF0FF000, 32'hB040BF4F, 32'hE919E616, 32'hA656A959,
    32'h75857A8A, 32'h3ACA35C5, 32'h63936C9C, 32'h2CDC23D3,
    32'hD222DD2D, 32'h9D6D9262, 32'hC434CB3B, 32'h8B7B8474,
    32'h58A857A7, 32'h17E718E8, 32'h4EBE41B1, 32'h01F10EFE};

  qaw_watchdog dut (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_second_window(win2),
    .timeout_event(tmo), .spi_cs_n(spi_cs_n), .question(question),
    .result(res), .first_window_length(w1len),
    .second_window_length(w2len), .sequence_restart(restart));

  qaw_mcu_model mcu (.clk(clk), .frame(frame), .spi_cs_n(spi_cs_n));

  always #25 clk = ~clk;

  task automatic complete_run();
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    slv = pslverr;
    rsr = restart;
    if (n >= 20) begin
      n_fail++;
      complete_run();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [31:0] rv(input logic [2:0] t, input logic sf,
                                     chg, pre, nr, mm);
    return {22'h0, t, 2'h3, sf, chg, pre, nr, mm};
  endfunction

  // Result register read; bit 0 compared only where it is defined
  task automatic chk_res(input logic [31:0] e, input logic mmcare);
    logic [31:0] m;
    m = mmcare ? 32'h3FF : 32'h3FE;
    apb(1'h0, 8'h04, 32'h0);
    chk(rd & m, e & m);
  endtask

  task automatic chk_q();
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, {28'h0, step ^ mk});
  endtask

  // Step counter and chain as expected after a good sequence
  task automatic adv();
    step = step + 4'h1;
    if (step == 4'h0) begin
      mk = {mk[2:0], ~(mk[3] ^ mk[2])};
    end
  endtask

  task automatic pulse();
    @(posedge clk);
    tmo <= 1'h1;
    @(posedge clk);
    tmo <= 1'h0;
  endtask

  // Controller writes bytes three down to zero
  task automatic seq(input logic bad, input logic late);
    logic [31:0] a;
    logic [7:0]  b;
    a = ans[step ^ mk];
    for (int i = 3; i >= 0; i--) begin
      b = a[8*i+:8] ^ ((bad && i == 1) ? 8'h5A : 8'h00);
      @(posedge clk);
      win2 <= (i == 0) ? late : 1'h0;
      apb(1'h1, 8'h08, {24'h0, b});
      #1;
      chk({31'h0, rsr}, {31'h0, i == 0});
      if (i > 0) chk(32'(res.answer_byte_index), 32'(i - 1));
    end
  endtask

  initial begin
    #(50 * 100000);
    n_fail++;
    complete_run();
  end

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    win2 = 1'h0;
    tmo = 1'h0;
    frame = 1'h0;
    n_fail = 0;
    checks = 0;
    step = 4'h0;
    mk = 4'h0;
    tally = 3'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    chk_q();
    chk_res(rv(3'h0, 0, 0, 0, 0, 0), 1'h1);
    // Early bytes in window one, final in window two, tally held at zero
    seq(1'h0, 1'h1);
    chk_res(rv(3'h0, 0, 0, 0, 0, 0), 1'h1);
    adv();
    chk_q();
    seq(1'h0, 1'h0);
    chk_res(rv(3'h1, 1, 0, 1, 0, 0), 1'h1);
    seq(1'h1, 1'h1);
    chk_res(rv(3'h2, 1, 0, 0, 0, 1), 1'h1);
    seq(1'h1, 1'h0);
    chk_res(rv(3'h3, 1, 0, 1, 0, 1), 1'h1);
    chk_q();
    // Wrong first byte, then no response
    apb(1'h1, 8'h08, {24'h0, ~ans[step ^ mk][31:24]});
    pulse();
    chk_res(rv(3'h4, 1, 0, 0, 1, 0), 1'h0);
    chk_q();
    // No response inside an SPI frame
    frame <= 1'h1;
    repeat (5) @(posedge clk);
    pulse();
    frame <= 1'h0;
    chk_res(rv(3'h5, 0, 0, 0, 0, 0), 1'h0);
    apb(1'h1, 8'h0C, 32'h0000005A);
    chk_res(rv(3'h6, 0, 1, 0, 0, 0), 1'h0);
    chk_q();
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0000005A);
    chk({24'h0, w1len}, 32'h0000005A);
    // Second window setting: another change, tally reaches its top
    apb(1'h1, 8'h10, 32'h0000003C);
    chk_res(rv(3'h7, 0, 1, 0, 0, 0), 1'h0);
    chk_q();
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0000003C);
    chk({24'h0, w2len}, 32'h0000003C);
    pulse();
    chk_res(rv(3'h7, 0, 0, 0, 1, 0), 1'h0);
    pulse();
    chk_res(rv(3'h7, 0, 0, 0, 1, 0), 1'h0);
    // Clock enable low: a window write and a time-out are ignored
    ce <= 1'h0;
    apb(1'h1, 8'h0C, 32'h00000011);
    pulse();
    ce <= 1'h1;
    chk_res(rv(3'h7, 0, 0, 0, 1, 0), 1'h0);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0000005A);
    tally = 3'h7;
    // Sixteen good sequences ask questions one to fifteen, then one again, and wrap the counter
    for (int k = 0; k < 16; k++) begin
      seq(1'h0, 1'h1);
      adv();
      chk({28'h0, question}, {28'h0, step ^ mk});
      tally = (tally == 3'h0) ? 3'h0 : tally - 3'h1;
      chk_res(rv(tally, 0, 0, 0, 0, 0), 1'h1);
      chk_q();
    end
    // Unmapped address and a write to the read-only question
    apb(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, slv}, 32'h1);
    apb(1'h1, 8'h00, 32'h0000000F);
    chk_q();
    complete_run();
  end
endmodule

// ### verif/qaw_mcu_model.sv
// Controller-side model: chip select framing of SPI transfers
`timescale 1ns/1ns
module qaw_mcu_model (
  // Clock and frame request from the bench
  input  wire logic clk,
  input  wire logic frame,
  // SPI chip select pin, idles high outside frames
  output logic      spi_cs_n
);
  initial spi_cs_n = 1'h1;

  // Select held low for a whole frame
  always @(posedge clk) begin
    spi_cs_n <= ~frame;
  end
endmodule
